// ---- serial_port_config_reset_ctrl_tb.sv ----
// Purpose: Self-checking bench of the serial control port
// Assumes: Host model owns the link clock and the frame timing
// Notes:   Expected values are worked out here from the register map
`timescale 1ns/100ps
`default_nettype none

module serial_port_config_reset_ctrl_tb;
   logic       mclk;
   logic       rst_n;
   wire        serialClk;
   wire        portSelectN;
   wire        serialDataIn;
   wire        serialDataOut;
   wire        serialDataOeN;
   wire        serialOutputLine;
   wire        serialOutputLineOeN;
   wire  [7:0] controlReg;
   wire  [1:0] referenceClockMultiplier;
   wire        systemClockStable;
   int         fails;
   int         samplesChecked;
   int         cycles;
   int         n;
   int         lowCnt;
   logic [7:0] w[4];
   logic [7:0] r[4];
   logic [7:0] pats[2];
   logic [7:0] mults[2];

   spc_serial_port u_spc_serial_port (
      .mclk(mclk), .rst_n(rst_n), .serialClk(serialClk), .portSelectN(portSelectN),
      .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
      .serialDataOeN(serialDataOeN), .serialOutputLine(serialOutputLine),
      .serialOutputLineOeN(serialOutputLineOeN), .controlReg(controlReg),
      .referenceClockMultiplier(referenceClockMultiplier),
      .systemClockStable(systemClockStable)
   );

   spc_host_model u_spc_host_model (
      .serialClk(serialClk), .portSelectN(portSelectN), .serialDataIn(serialDataIn),
      .serialDataOut(serialDataOut), .serialDataOeN(serialDataOeN),
      .serialOutputLine(serialOutputLine), .serialOutputLineOeN(serialOutputLineOeN)
   );

   ////////////////////////////////////////////////////////////////////////
   // Master clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         $display("Timeout after %0d cycles", cycles);
         finish_test();
      end
   end

   // Low time of the stable flag, counted from its fall, not from a task's return
   always @(negedge mclk) begin
      if (systemClockStable === 1'b0 && lowCnt < 255)
         lowCnt++;
   end

   ////////////////////////////////////////////////////////////////////////
   // Comparison, transfers and closing report
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr1(input logic [4:0] a, input logic [7:0] d);
      w = '{d, 8'h00, 8'h00, 8'h00};
      u_spc_host_model.frame({3'b000, a}, w, 0, r);
   endtask : wr1

   task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
      u_spc_host_model.frame({3'b100, a}, w, 0, r);
      check("read data", r[0], exp);
   endtask : rdchk

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      fails = 0;
      samplesChecked = 0;
      cycles = 0;
      lowCnt = 0;
      rst_n = 1'b0;
      pats  = '{8'h24, 8'he7};
      mults = '{8'h0c, 8'hc4};
      #3 u_spc_host_model.pulse(4, 1'b1);
      @(negedge mclk) rst_n = 1'b1;
      u_spc_host_model.pulse(3, 1'b1);
      check("control", controlReg, 8'h00);
      check("multiplier", {6'h00, referenceClockMultiplier}, 8'h00);
      check("stable", {7'h00, systemClockStable}, 8'h01);
      rdchk(5'h03, 8'h00);
      $display("Test reset done");
      // Single and multibyte transfers, MSB first steps down
      wr1(5'h03, 8'ha5);
      rdchk(5'h03, 8'ha5);
      w = '{8'h11, 8'h22, 8'h33, 8'h00};
      u_spc_host_model.frame(8'h45, w, 0, r);
      u_spc_host_model.frame(8'hc5, w, 0, r);
      for (int k = 0; k < 3; k++) check("burst", r[k], w[k]);
      $display("Test burst done");
      // Frame cut after 13 bits must leave the word alone
      w = '{8'hff, 8'h00, 8'h00, 8'h00};
      u_spc_host_model.frame(8'h02, w, 13, r);
      rdchk(5'h02, 8'h00);
      $display("Test abort done");
      // Configuration switched mid-frame, both address wraps
      w = '{8'h00, 8'h77, 8'h00, 8'h00};
      u_spc_host_model.frame(8'h20, w, 0, r);
      rdchk(5'h1f, 8'h77);
      w = '{8'h40, 8'h66, 8'h00, 8'h00};
      u_spc_host_model.frame(8'h20, w, 0, r);
      check("control", controlReg, 8'h40);
      rdchk(5'h01, 8'h66);
      w = '{8'h55, 8'h00, 8'h00, 8'h00};
      u_spc_host_model.frame(8'h3f, w, 0, r);
      check("control", controlReg, 8'h00);
      rdchk(5'h1f, 8'h55);
      wr1(5'h00, 8'h80);
      rdchk(5'h1f, 8'h55);
      wr1(5'h00, 8'h00);
      $display("Test config done");
      // Software reset in the middle of a frame
      w = '{8'h12, 8'h20, 8'h34, 8'h00};
      u_spc_host_model.frame(8'h41, w, 0, r);
      check("control", controlReg, 8'h20);
      rdchk(5'h01, 8'h00);
      rdchk(5'h03, 8'h00);
      rdchk(5'h1f, 8'h34);
      wr1(5'h00, 8'h00);
      $display("Test soft reset done");
      // Recovery pattern, multiplier update and wake-up time
      for (int c = 0; c < 2; c++) begin
         wr1(5'h01, 8'h99);
         wr1(5'h00, pats[c]);
         check("control", controlReg, pats[c]);
         rdchk(5'h01, 8'h00);
         lowCnt = 0;
         wr1(5'h00, mults[c]);
         n = 0;
         while (systemClockStable !== 1'b0 && n < 20) begin
            @(negedge mclk);
            n++;
         end
         n = 0;
         while (systemClockStable === 1'b0 && n < 400) begin
            @(negedge mclk);
            n++;
         end
         check("multiplier", {6'h00, referenceClockMultiplier}, {6'h00, mults[c][3:2]});
         check("wake cycles", 8'(lowCnt), 8'hc8);
         wr1(5'h00, {pats[c][7:6], 6'b001000});
         repeat (10) @(negedge mclk);
         check("multiplier", {6'h00, referenceClockMultiplier}, {6'h00, mults[c][3:2]});
      end
      $display("Test recovery done");
      finish_test();
   end

endmodule : serial_port_config_reset_ctrl_tb

`default_nettype wire

// ---- spc_cfg.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by bare name from package and design files
// Notes:   Definitions only
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// Register map and port geometry
`define SPC_ADDR_W        5
`define SPC_REG_DEPTH     32
`define SPC_CTRL_ADDR     5'h00
`define SPC_CTRL_RESET    8'h00
`define SPC_REG_DEFAULT   8'h00

// Control register fields
`define SPC_BIDIR_BIT     7
`define SPC_LSB_BIT       6
`define SPC_SRST_BIT      5
`define SPC_MULT_LSB      2

// Instruction byte fields
`define SPC_INSTR_RD_BIT  7
`define SPC_INSTR_N_LSB   5
`define SPC_INSTR_A_LSB   0

// Wake-up time after a multiplier change, in master clock cycles (200)
`define SPC_WAKE_CYCLES   8'hc8

`endif

// ---- spc_host_model.sv ----
// Purpose: Serial port master that frames register transfers
// Assumes: Link clock idles low; it runs inside frames and in the bare pulses around hard reset
// Notes:   Follows the written configuration byte by byte, even mid-frame
`timescale 1ns/100ps
`default_nettype none

module spc_host_model (
   output logic serialClk,
   output logic portSelectN,
   output logic serialDataIn,
   input  wire logic serialDataOut,
   input  wire logic serialDataOeN,
   input  wire logic serialOutputLine,
   input  wire logic serialOutputLineOeN
);
   logic hostBit;
   logic hostOeN;
   logic lsbMode;
   logic bidirMode;
   logic lineNow;

   ////////////////////////////////////////////////////////////////////////
   // Shared pin: a released pin shows junk, never the last bit driven
   assign serialDataIn = !serialDataOeN ? serialDataOut : (hostOeN ? ~hostBit : hostBit);
   assign lineNow = bidirMode ? serialDataIn
                    : (!serialOutputLineOeN ? serialOutputLine : ~hostBit);

   initial begin
      serialClk   = 1'b0;
      portSelectN = 1'b1;
      hostBit     = 1'b0;
      hostOeN     = 1'b0;
      lsbMode     = 1'b0;
      bidirMode   = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Bare clock edges, used only around hard reset
   task automatic pulse(input int n, input logic sel);
      portSelectN = sel;
      repeat (n) begin
         #32 serialClk = 1'b1;
         #32 serialClk = 1'b0;
      end
      portSelectN = 1'b1;
   endtask : pulse

   // One frame; cut stops after that many bits (0 runs it whole)
   task automatic frame(input logic [7:0] instr, input logic [7:0] wr[4],
                        input int cut, output logic [7:0] rd[4]);
      int n;
      int cnt;
      int idx;
      logic [4:0] a;
      logic [7:0] b;
      n = int'(instr[6:5]) + 1;
      a = instr[4:0];
      cnt = 0;
      rd = '{4{8'h00}};
      #20 portSelectN = 1'b0;
      for (int k = 0; k <= n; k++) begin
         b = (k == 0) ? instr : wr[k-1];
         hostOeN = (k > 0) && instr[7] && bidirMode;
         for (int i = 0; i < 8; i++) begin
            if (cut == 0 || cnt < cut) begin
               idx = lsbMode ? i : 7 - i;
               hostBit = (k > 0 && instr[7]) ? ~hostBit : b[idx];
               #31;
               if (k > 0 && instr[7]) b[idx] = lineNow;
               #1 serialClk = 1'b1;
               cnt++;
               #32 serialClk = 1'b0;
            end
         end
         if (k > 0) begin
            if (instr[7]) rd[k-1] = b;
            else if (a == 5'h00) begin
               lsbMode   = b[6];
               bidirMode = b[7];
            end
            a = lsbMode ? 5'(a + 5'h01) : 5'(a - 5'h01);
         end
      end
      #20 portSelectN = 1'b1;
      hostOeN = 1'b0;
      #40;
   endtask : frame

endmodule : spc_host_model

`default_nettype wire

// ---- spc_mem_if.sv ----
// Purpose: Carrier between the port logic and its register memory
// Assumes: All signals live in the serial clock domain
// Notes:   clear drops every stored register back to its default
`timescale 1ns/100ps
`default_nettype none

interface spc_mem_if;
   logic       wrEn;
   logic [4:0] wrAddr;
   logic [7:0] wrData;
   logic [4:0] rdAddr;
   logic [7:0] rdData;
   logic       clear;

   modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr,
                 output clear, input rdData);
   modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr,
                 input clear, output rdData);
endinterface : spc_mem_if

`default_nettype wire

// ---- spc_pkg.sv ----
// Purpose: Types and helper functions of the serial control port
// Assumes: spc_cfg.svh holds the numbers
// Notes:   Functions are shared by the link-side logic and its checks
`default_nettype none
`include "spc_cfg.svh"

package spc_pkg;

   // Port phase within one chip-select frame
   typedef enum logic [1:0] {
      PH_INSTR = 2'b00,
      PH_DATA  = 2'b01,
      PH_DONE  = 2'b10
   } spc_phase_type;

   // Byte address step: up in LSB-first, down in MSB-first; wraps in 5 bits
   function automatic logic [4:0] spc_next_addr(input logic [4:0] a, input logic lsb);
      spc_next_addr = lsb ? 5'(a + 5'h01) : 5'(a - 5'h01);
   endfunction : spc_next_addr

   // Bit that leaves the port first for the given order
   function automatic logic spc_first_bit(input logic [7:0] b, input logic lsb);
      spc_first_bit = lsb ? b[0] : b[7];
   endfunction : spc_first_bit

   // Move the outgoing byte one place
   function automatic logic [7:0] spc_shift_out(input logic [7:0] b, input logic lsb);
      spc_shift_out = lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
   endfunction : spc_shift_out

   // Recovery pattern XY1001YX, symmetric so either bit order decodes it
   function automatic logic spc_is_recovery(input logic [7:0] b);
      spc_is_recovery = (b[5:2] == 4'h9) && (b[1] == b[6]) && (b[0] == b[7]);
   endfunction : spc_is_recovery

endpackage : spc_pkg

`default_nettype wire

// ---- spc_reg_mem.sv ----
// Purpose: 32 x 8 register memory with one-edge clear to defaults
// Assumes: Single clock, registered read data
// Notes:   A valid bit per word makes the clear immediate without
//          touching the array itself
`timescale 1ns/100ps
`default_nettype none
`include "spc_cfg.svh"

module spc_reg_mem
   import spc_pkg::*;
(
   input wire logic clk,
   spc_mem_if.mem   bus
);

   logic [7:0]                 store [`SPC_REG_DEPTH];
   logic [`SPC_REG_DEPTH-1:0]  valid_q;
   logic [7:0]                 rdData_q;

   ////////////////////////////////////////////////////////////////////////
   // Array write, no reset needed since valid bits gate the reads
   always_ff @(posedge clk) begin
      if (bus.wrEn) begin
         store[bus.wrAddr] <= bus.wrData;
      end
   end

   // Clear wins over a write in the same edge
   always_ff @(posedge clk) begin
      if (bus.clear) begin
         valid_q <= '0;
      end else if (bus.wrEn) begin
         valid_q[bus.wrAddr] <= 1'b1;
      end
   end

   // Registered read; unwritten words read their default
   always_ff @(posedge clk) begin
      rdData_q <= valid_q[bus.rdAddr] ? store[bus.rdAddr] : `SPC_REG_DEFAULT;
   end

   assign bus.rdData = rdData_q;

   ////////////////////////////////////////////////////////////////////////
   // Soft reset empties the memory in one edge
   a_clear_all: assert property (@(posedge clk) bus.clear |=> valid_q == '0)
      else $error("register memory not cleared by reset");

endmodule : spc_reg_mem

`default_nettype wire

// ---- spc_serial_port.sv ----
// Purpose: Serial register port with configuration, software reset,
//          configuration recovery and clock multiplier reprogramming
// Assumes: serialClk runs inside frames and in bare pulses around hard reset; portSelectN high ends a frame
// Notes:   Hard reset reaches the link side on serialClk edges only
`timescale 1ns/100ps
`default_nettype none
`include "spc_cfg.svh"

// Summary of operation
// - Port configuration lives in control register bits 7 and 6.
// - New configuration acts as soon as the control byte's last bit arrives.
// - Remaining bytes of the frame use the newly written format.
// - Software reset acts when its byte completes, even mid-frame.
// - Software reset defaults all registers except the control register.
// - Pattern XY1001YX restores configuration and defaults all registers except the control register.
// - Next control write, reset low, same XY, reprograms clock multiplier.
// - System clock is stable at most 200 master cycles after multiplier change.
// - Instruction byte: read flag, byte count, start address.
// - Chip select high restarts at instruction; partial bytes never write.
// - Control bit 7 turns data pin bidirectional; default uses output line.
// - Address increments in LSB-first, decrements in MSB-first, 5-bit wrap.
module spc_serial_port
   import spc_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       serialClk,
   input  wire logic       portSelectN,
   input  wire logic       serialDataIn,
   output logic            serialDataOut,
   output logic            serialDataOeN,
   output logic            serialOutputLine,
   output logic            serialOutputLineOeN,
   output logic [7:0]      controlReg,
   output logic [1:0]      referenceClockMultiplier,
   output logic            systemClockStable
);

   spc_mem_if memBus ();

   logic          rstMeta_q, rstSync_q;
   spc_phase_type phase_q;
   logic [2:0]    bitCnt_q;
   logic [6:0]    shift_q;
   logic          isRead_q;
   logic [1:0]    bytesLeft_q;
   logic [4:0]    addr_q;
   logic [7:0]    ctrl_q;
   logic          armMult_q;
   logic [1:0]    multCode_q;
   logic          multTgl_q;
   logic          rdCtrl_q;
   logic [7:0]    tx_q;
   logic          txBit_q;
   logic          tglMeta_q, tglSync_q, tglSeen_q;
   logic [1:0]    mult_q;
   logic [7:0]    wakeCnt_q, wakeCnt_d;
   logic          stable_q;

   logic          lsbMode, newLsb, byteDone, instrDone, dataByteDone;
   logic          writeCtrl, writeMem, multWrite, softReset, readActive;
   logic [7:0]    byteIn, readByte;
   logic [6:0]    shiftNext;
   logic [4:0]    stepAddr;
   logic          multLoad;

   ////////////////////////////////////////////////////////////////////////
   // Link-side decode
   assign lsbMode      = ctrl_q[`SPC_LSB_BIT];
   assign byteIn       = lsbMode ? {serialDataIn, shift_q} : {shift_q, serialDataIn};
   assign shiftNext    = lsbMode ? {serialDataIn, shift_q[6:1]} : {shift_q[5:0], serialDataIn};
   assign byteDone     = (bitCnt_q == 3'h7);
   assign instrDone    = byteDone && (phase_q == PH_INSTR);
   assign dataByteDone = byteDone && (phase_q == PH_DATA);
   assign writeCtrl    = dataByteDone && !isRead_q && (addr_q == `SPC_CTRL_ADDR);
   assign writeMem     = dataByteDone && !isRead_q && (addr_q != `SPC_CTRL_ADDR);
   assign softReset    = writeCtrl && byteIn[`SPC_SRST_BIT];
   assign multWrite    = writeCtrl && armMult_q && !byteIn[`SPC_SRST_BIT]
                         && (byteIn[7:6] == ctrl_q[7:6]);
   // Order of the bytes still to come follows the byte just written
   assign newLsb       = writeCtrl ? byteIn[`SPC_LSB_BIT] : lsbMode;
   assign stepAddr     = spc_next_addr(addr_q, newLsb);
   assign readActive   = (phase_q == PH_DATA) && isRead_q;

   // Memory port: read is fetched on the edge that ends a byte
   assign memBus.wrEn   = writeMem;
   assign memBus.wrAddr = addr_q;
   assign memBus.wrData = byteIn;
   assign memBus.rdAddr = (phase_q == PH_INSTR) ? byteIn[4:0] : stepAddr;
   assign memBus.clear  = softReset || !rstSync_q;

   spc_reg_mem u_mem (
      .clk (serialClk),
      .bus (memBus)
   );

   ////////////////////////////////////////////////////////////////////////
   // Hard reset brought into the link domain
   always_ff @(posedge serialClk) begin
      rstMeta_q <= rst_n;
      rstSync_q <= rstMeta_q;
   end

   // Bit counter and shifter; chip select high clears them at once
   always_ff @(posedge serialClk or posedge portSelectN) begin
      if (portSelectN) begin
         bitCnt_q <= 3'h0;
         shift_q  <= 7'h00;
      end else if (phase_q != PH_DONE) begin
         bitCnt_q <= 3'(bitCnt_q + 3'h1);
         shift_q  <= shiftNext;
      end
   end

   // Frame phase, instruction fields and byte address
   always_ff @(posedge serialClk or posedge portSelectN) begin
      if (portSelectN) begin
         phase_q     <= PH_INSTR;
         isRead_q    <= 1'b0;
         bytesLeft_q <= 2'h0;
         addr_q      <= 5'h00;
      end else begin
         case (phase_q)
            PH_INSTR: begin
               if (byteDone) begin
                  isRead_q    <= byteIn[`SPC_INSTR_RD_BIT];
                  bytesLeft_q <= byteIn[`SPC_INSTR_N_LSB +: 2];
                  addr_q      <= byteIn[`SPC_INSTR_A_LSB +: 5];
                  phase_q     <= PH_DATA;
               end
            end
            PH_DATA: begin
               if (byteDone) begin
                  addr_q      <= stepAddr;
                  bytesLeft_q <= 2'(bytesLeft_q - 2'h1);
                  phase_q     <= (bytesLeft_q == 2'h0) ? PH_DONE : PH_DATA;
               end
            end
            PH_DONE: begin
               phase_q <= PH_DONE;
            end
            default: begin
               phase_q <= PH_INSTR;
            end
         endcase
      end
   end

   // Control register survives soft reset and chip select; takes effect at once
   always_ff @(posedge serialClk) begin
      if (!rstSync_q) begin
         ctrl_q    <= `SPC_CTRL_RESET;
         armMult_q <= 1'b0;
      end else if (writeCtrl) begin
         ctrl_q    <= byteIn;
         armMult_q <= spc_is_recovery(byteIn);
      end
   end

   // Multiplier code is held still while its toggle crosses to mclk
   always_ff @(posedge serialClk) begin
      if (!rstSync_q) begin
         multCode_q <= 2'h0;
         multTgl_q  <= 1'b0;
      end else if (multWrite) begin
         multCode_q <= byteIn[`SPC_MULT_LSB +: 2];
         multTgl_q  <= ~multTgl_q;
      end
   end

   // Remember whether the fetched byte is the control register
   always_ff @(posedge serialClk) begin
      rdCtrl_q <= (memBus.rdAddr == `SPC_CTRL_ADDR);
   end

   assign readByte = rdCtrl_q ? ctrl_q : memBus.rdData;

   ////////////////////////////////////////////////////////////////////////
   // Read data leave on falling edges, first bit right after the byte edge
   always_ff @(negedge serialClk or posedge portSelectN) begin
      if (portSelectN) begin
         tx_q    <= 8'h00;
         txBit_q <= 1'b0;
      end else if (readActive && (bitCnt_q == 3'h0)) begin
         tx_q    <= readByte;
         txBit_q <= spc_first_bit(readByte, lsbMode);
      end else if (readActive) begin
         tx_q    <= spc_shift_out(tx_q, lsbMode);
         txBit_q <= spc_first_bit(spc_shift_out(tx_q, lsbMode), lsbMode);
      end
   end

   // Pin direction: enables are low while driving, high outside a read
   assign serialDataOut       = txBit_q;
   assign serialOutputLine    = txBit_q;
   assign serialDataOeN       = !(readActive && !portSelectN && ctrl_q[`SPC_BIDIR_BIT]);
   assign serialOutputLineOeN = !(readActive && !portSelectN && !ctrl_q[`SPC_BIDIR_BIT]);
   assign controlReg          = ctrl_q;

   ////////////////////////////////////////////////////////////////////////
   // Master clock side: toggle synchroniser, edge seen from the second stage
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tglMeta_q <= 1'b0;
         tglSync_q <= 1'b0;
         tglSeen_q <= 1'b0;
      end else begin
         tglMeta_q <= multTgl_q;
         tglSync_q <= tglMeta_q;
         tglSeen_q <= tglSync_q;
      end
   end

   assign multLoad  = tglSync_q ^ tglSeen_q;
   // A fresh change restarts the wait, so back-to-back writes stay safe
   assign wakeCnt_d = multLoad ? `SPC_WAKE_CYCLES
                    : (wakeCnt_q != 8'h00) ? 8'(wakeCnt_q - 8'h01) : 8'h00;

   // Multiplier setting and wake-up count
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mult_q    <= 2'h0;
         wakeCnt_q <= 8'h00;
         stable_q  <= 1'b1;
      end else begin
         mult_q    <= multLoad ? multCode_q : mult_q;
         wakeCnt_q <= wakeCnt_d;
         stable_q  <= (wakeCnt_d == 8'h00);
      end
   end

   assign referenceClockMultiplier = mult_q;
   assign systemClockStable        = stable_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the link side
   sequence s_recover;
      writeCtrl && spc_is_recovery(byteIn);
   endsequence

   // Armed control write, reset bit low, configuration bits unchanged
   sequence s_mult_write;
      writeCtrl && armMult_q && !byteIn[`SPC_SRST_BIT] && byteIn[7:6] == ctrl_q[7:6];
   endsequence

   a_cfg_bits: assert property (@(posedge serialClk) disable iff (!rstSync_q)
      writeCtrl |=> ctrl_q[7:6] == $past(byteIn[7:6]))
      else $error("configuration bits not stored");

   a_cfg_immediate: assert property (@(posedge serialClk)
      disable iff (portSelectN || !rstSync_q)
      writeCtrl && phase_q == PH_DATA && bytesLeft_q != 2'h0
      |=> lsbMode == $past(byteIn[`SPC_LSB_BIT]) && phase_q == PH_DATA)
      else $error("new configuration not in force for next byte");

   a_addr_step: assert property (@(posedge serialClk)
      disable iff (portSelectN || !rstSync_q)
      dataByteDone && bytesLeft_q != 2'h0
      |=> addr_q == (lsbMode ? 5'($past(addr_q) + 5'h01) : 5'($past(addr_q) - 5'h01)))
      else $error("address did not step in current order");

   a_srst_clear: assert property (@(posedge serialClk) disable iff (!rstSync_q)
      writeCtrl && byteIn[`SPC_SRST_BIT] |-> memBus.clear && !memBus.wrEn)
      else $error("software reset not applied at byte end");

   a_ctrl_kept: assert property (@(posedge serialClk) disable iff (!rstSync_q)
      writeCtrl && byteIn[`SPC_SRST_BIT] |=> ctrl_q == $past(byteIn))
      else $error("control register disturbed by reset");

   a_recover_arm: assert property (@(posedge serialClk)
      disable iff (!rstSync_q)
      s_recover |-> memBus.clear ##1 armMult_q)
      else $error("recovery write not recognised");

   a_mult_prog: assert property (@(posedge serialClk) disable iff (!rstSync_q)
      s_mult_write |=> multTgl_q != $past(multTgl_q) && !armMult_q)
      else $error("multiplier write not taken");

   a_instr_decode: assert property (@(posedge serialClk) disable iff (portSelectN)
      instrDone |=> isRead_q == $past(byteIn[7]) && bytesLeft_q == $past(byteIn[6:5])
      && addr_q == $past(byteIn[4:0]))
      else $error("instruction byte decoded wrongly");

   a_pin_select: assert property (@(posedge serialClk) disable iff (!rstSync_q)
      !(serialDataOeN == 1'b0 && serialOutputLineOeN == 1'b0)
      && (serialOutputLineOeN || !ctrl_q[`SPC_BIDIR_BIT]))
      else $error("wrong data pin driven");

   // Checks on the master clock side
   a_wake_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      multLoad |=> !systemClockStable [*8])
      else $error("clock reported stable too early");

   a_wake_bound: assert property (@(posedge mclk) disable iff (!rst_n)
      multLoad ##1 !multLoad [*8] |-> ##193 systemClockStable)
      else $error("wake-up wait longer than 200 cycles");

endmodule : spc_serial_port

`default_nettype wire
